// ==== i2coa_top.sv ====
// own-address recognition, bus timing and register port of the i2c controller
// assumes the receive engine and register master share ref_clk; scl pin is asynchronous
`timescale 1ns/10ps
`include "i2coa_map.svh"

// Behaviour
// - 7-bit mode compares first address bits 7:1
// - 10-bit mode compares first address bits 9:0
// - bit 10 selects 7 or 10 bit length
// - first address disabled gives NACK
// - second address masked by 3-bit code
// - mask code 111 acknowledges any non-reserved 7-bit address
// - masked match never acknowledges reserved addresses
// - second address disabled gives NACK
// - scl low lasts low count plus one, or hold plus setup plus one if that is longer
// - scl high lasts high count plus one
// - sda changes hold count after falling edge
// - setup count plus one before rising edge
// - kernel clock divided by prescaler plus one
// - match sets flag; clear bit or disable
module i2coa_top import i2coa_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // received address from the bit engine
    input wire i2coa_rxaddr_t rxAddr,
    // address decision
    output logic addrDone,
    output logic addrAck,
    output logic addressMatchFlag,
    output logic peripheralEnable,
    // interrupt
    output logic irq,
    // scl open-drain pin and sda strobe
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaChange
);

    localparam int RST_N = `I2COA_RST_STAGES;

    // ==========================================================
    // reset release
    logic [RST_N-1:0] rstPipe_q;
    wire rstSyncN = rstPipe_q[RST_N-1];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_q <= '0;
        end else begin
            rstPipe_q <= {rstPipe_q[RST_N-2:0], 1'b1};
        end
    end

    // ==========================================================
    // decode helpers
    function automatic logic isReserved(input logic [6:0] a);
        isReserved = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
    endfunction

    // compare mask for the second address: a one keeps the bit in the comparison
    function automatic logic [6:0] keepBits(input logic [2:0] code);
        logic [6:0] m;
        m = 7'h7f;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(code)) begin
                m[i] = 1'b0;
            end
        end
        keepBits = m;
    endfunction

    // ==========================================================
    // registers
    logic [31:0] primary_own_addr_q, secondary_own_addr_q, timing_q, ctrl_q, status_q, mask_q;
    logic [31:0] rdata_q;
    logic ackDone_q, ack_q, irq_q;

    wire wrAddr1 = regWr && (regAddr == `I2COA_OFS_PRIMARY_OWN_ADDR);
    wire wrAddr2 = regWr && (regAddr == `I2COA_OFS_SECONDARY_OWN_ADDR);
    wire wrTiming = regWr && (regAddr == `I2COA_OFS_TIMING);
    wire wrCtrl = regWr && (regAddr == `I2COA_OFS_CTRL);
    wire wrStatus = regWr && (regAddr == `I2COA_OFS_STATUS);
    wire wrMask = regWr && (regAddr == `I2COA_OFS_MASK);

    wire enable = ctrl_q[`I2COA_CTRL_ENABLE_BIT];
    wire clockRun = ctrl_q[`I2COA_CTRL_RUN_BIT];

    // ==========================================================
    // own-address comparison
    wire len10 = primary_own_addr_q[`I2COA_PRIMARY_OWN_ADDR_LEN_BIT];
    wire en1 = primary_own_addr_q[`I2COA_ADDR_EN_BIT];
    wire en2 = secondary_own_addr_q[`I2COA_ADDR_EN_BIT];
    wire [2:0] mask2 = secondary_own_addr_q[`I2COA_SECONDARY_OWN_ADDR_MSK_LSB+:3];
    wire [6:0] keep2 = keepBits(mask2);
    wire rxReserved = isReserved(rxAddr.addr[6:0]);

    wire hit1Short = !len10 && !rxAddr.is10 && (rxAddr.addr[6:0] == primary_own_addr_q[7:1]);
    wire hit1Long = len10 && rxAddr.is10 && (rxAddr.addr == primary_own_addr_q[9:0]);
    wire hit1 = hit1Short || hit1Long;

    // code 111 leaves nothing to compare, so every non-reserved 7-bit address hits
    wire hit2Raw = !rxAddr.is10 && (((rxAddr.addr[6:0] ^ secondary_own_addr_q[7:1]) & keep2) == 7'h0);
    wire hit2 = hit2Raw && !((mask2 != 3'h0) && rxReserved);

    // a hit on a disabled comparator answers nack
    wire ackNow = (hit1 && en1) || (hit2 && en2);
    wire rxEvent = rxAddr.valid && enable;
    wire matchEvt = rxEvent && ackNow;
    wire noMatchEvt = rxEvent && !ackNow;

    // ==========================================================
    // register writes
    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            primary_own_addr_q <= `I2COA_RESET_VALUE;
            secondary_own_addr_q <= `I2COA_RESET_VALUE;
            timing_q <= `I2COA_RESET_VALUE;
            ctrl_q <= `I2COA_RESET_VALUE;
            mask_q <= `I2COA_RESET_VALUE;
        end else begin
            if (wrAddr1) begin
                primary_own_addr_q <= regWdata & `I2COA_PRIMARY_OWN_ADDR_WMASK;
            end
            if (wrAddr2) begin
                secondary_own_addr_q <= regWdata & `I2COA_SECONDARY_OWN_ADDR_WMASK;
            end
            // a running sequencer would tear on a mid-bit change
            if (wrTiming && !enable) begin
                timing_q <= regWdata & `I2COA_TIMING_WMASK;
            end
            if (wrCtrl) begin
                ctrl_q <= regWdata & `I2COA_CTRL_WMASK;
            end
            if (wrMask) begin
                mask_q <= regWdata & `I2COA_EVT_WMASK;
            end
        end
    end

    // ==========================================================
    // sticky events: set wins over write-one-clear, disable clears
    wire [31:0] evtSet = {30'h0, noMatchEvt, matchEvt};
    wire [31:0] evtClr = wrStatus ? (regWdata & `I2COA_EVT_WMASK) : 32'h0;
    wire [31:0] statusD = enable ? ((status_q & ~evtClr) | evtSet) : 32'h0;

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            status_q <= `I2COA_RESET_VALUE;
            irq_q <= 1'b0;
        end else begin
            status_q <= statusD;
            irq_q <= |(statusD & mask_q);
        end
    end

    // ==========================================================
    // address decision and read port
    wire [31:0] rdSel =
        (regAddr == `I2COA_OFS_PRIMARY_OWN_ADDR) ? primary_own_addr_q :
        (regAddr == `I2COA_OFS_SECONDARY_OWN_ADDR) ? secondary_own_addr_q :
        (regAddr == `I2COA_OFS_TIMING) ? timing_q :
        (regAddr == `I2COA_OFS_CTRL) ? ctrl_q :
        (regAddr == `I2COA_OFS_STATUS) ? status_q :
        (regAddr == `I2COA_OFS_MASK) ? mask_q : 32'h0;

    always_ff @(posedge ref_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ackDone_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ackDone_q <= rxEvent;
            if (rxEvent) begin
                ack_q <= ackNow;
            end
            rdata_q <= regRd ? rdSel : 32'h0;
        end
    end

    // ==========================================================
    // bus timing sequencer
    i2coa_timing #(
        .CNT_W(9)
    ) u_timing (
        .clk(ref_clk),
        .rstSyncN(rstSyncN),
        .run(enable && clockRun),
        .cfg(i2coa_timing_cfg_t'(timing_q)),
        .sclIn(sclIn),
        .sclOut(sclOut),
        .sclOe(sclOe),
        .sdaChange(sdaChange)
    );

    assign regRdata = rdata_q;
    assign addrDone = ackDone_q;
    assign addrAck = ack_q;
    assign addressMatchFlag = status_q[`I2COA_EVT_MATCH_BIT];
    assign peripheralEnable = ctrl_q[`I2COA_CTRL_ENABLE_BIT];
    assign irq = irq_q;

    // ==========================================================
    // checks
    property p_short_match;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && !len10 && en1 && !rxAddr.is10 && rxAddr.addr[6:0] == primary_own_addr_q[7:1]
            |=> addrDone && addrAck;
    endproperty
    a_short_match: assert property (p_short_match) else $error("7-bit own address not acked");

    property p_long_match;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && len10 && en1 && rxAddr.is10 && rxAddr.addr == primary_own_addr_q[9:0]
            |=> addrDone && addrAck;
    endproperty
    a_long_match: assert property (p_long_match) else $error("10-bit own address not acked");

    property p_len_gate;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && len10 && !rxAddr.is10 && !(hit2 && en2) |=> addrDone && !addrAck;
    endproperty
    a_len_gate: assert property (p_len_gate) else $error("7-bit address acked in 10-bit mode");

    property p_en1_off;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && hit1 && !en1 && !(hit2 && en2) |=> !addrAck;
    endproperty
    a_en1_off: assert property (p_en1_off) else $error("disabled first address acked");

    property p_mask_all;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && en2 && mask2 == 3'h7 && !rxAddr.is10 && !rxReserved |=> addrAck;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("mask 111 did not ack");

    property p_mask_one;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && en2 && mask2 == 3'h1 && !rxAddr.is10 && !rxReserved &&
            rxAddr.addr[6:1] == secondary_own_addr_q[7:2] |=> addrAck;
    endproperty
    a_mask_one: assert property (p_mask_one) else $error("mask 001 compare wrong");

    property p_reserved;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && mask2 != 3'h0 && rxReserved && !(hit1 && en1) |=> !addrAck;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address acked by mask");

    property p_en2_off;
        @(posedge ref_clk) disable iff (!rstSyncN)
        rxEvent && !en2 && !(hit1 && en1) |=> addrDone && !addrAck;
    endproperty
    a_en2_off: assert property (p_en2_off) else $error("disabled second address acked");

    property p_flag_set;
        @(posedge ref_clk) disable iff (!rstSyncN)
        matchEvt |=> addressMatchFlag && addrAck ##1
            (addressMatchFlag || !$past(enable) || $past(evtClr[0]));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("match flag not set");

    property p_flag_off;
        @(posedge ref_clk) disable iff (!rstSyncN)
        !enable |=> !addressMatchFlag;
    endproperty
    a_flag_off: assert property (p_flag_off) else $error("flag survived disable");

    property p_timing_lock;
        @(posedge ref_clk) disable iff (!rstSyncN)
        wrTiming && enable |=> $stable(timing_q);
    endproperty
    a_timing_lock: assert property (p_timing_lock) else $error("timing changed while enabled");

    c_ack: cover property (@(posedge ref_clk) disable iff (!rstSyncN) addrDone && addrAck);
    c_nack: cover property (@(posedge ref_clk) disable iff (!rstSyncN) addrDone && !addrAck);
    c_irq: cover property (@(posedge ref_clk) disable iff (!rstSyncN) $rose(irq));
    c_long: cover property (@(posedge ref_clk) disable iff (!rstSyncN) matchEvt && hit1Long);

endmodule

// ==== i2coa_map.svh ====
// register offsets, field positions, reset values and timing for the own-address block
// assumes an 8-bit byte address on the plain register port
`ifndef I2COA_MAP_SVH
`define I2COA_MAP_SVH

`define I2COA_OFS_PRIMARY_OWN_ADDR 8'h08
`define I2COA_OFS_SECONDARY_OWN_ADDR 8'h0c
`define I2COA_OFS_TIMING 8'h10
`define I2COA_OFS_CTRL 8'h20
`define I2COA_OFS_STATUS 8'h24
`define I2COA_OFS_MASK 8'h28

`define I2COA_PRIMARY_OWN_ADDR_LEN_BIT 10
`define I2COA_ADDR_EN_BIT 15
`define I2COA_SECONDARY_OWN_ADDR_MSK_LSB 8
`define I2COA_CTRL_ENABLE_BIT 0
`define I2COA_CTRL_RUN_BIT 1
`define I2COA_EVT_MATCH_BIT 0
`define I2COA_EVT_NOMATCH_BIT 1

`define I2COA_PRIMARY_OWN_ADDR_WMASK 32'h0000_87ff
`define I2COA_SECONDARY_OWN_ADDR_WMASK 32'h0000_87fe
`define I2COA_TIMING_WMASK 32'hf0ff_ffff
`define I2COA_CTRL_WMASK 32'h0000_0003
`define I2COA_EVT_WMASK 32'h0000_0003
`define I2COA_RESET_VALUE 32'h0000_0000

`define I2COA_CLK_PERIOD_NS 100
`define I2COA_RST_STAGES 2

`endif

// ==== i2coa_pkg.sv ====
// types shared by the own-address and timing logic
// assumes the map header supplies every number
package i2coa_pkg;

    // address as delivered by the bit-level receive engine
    typedef struct packed {
        logic valid;
        logic is10;
        logic [9:0] addr;
    } i2coa_rxaddr_t;

    // timing fields as laid out in the timing register
    typedef struct packed {
        logic [3:0] psc;
        logic [3:0] rsvd;
        logic [3:0] setup;
        logic [3:0] hold;
        logic [7:0] high;
        logic [7:0] low;
    } i2coa_timing_cfg_t;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_LOW,
        TS_HIGH
    } i2coa_tstate_t;

endpackage

// ==== i2coa_timing.sv ====
// scl low/high and sda hold/setup sequencer on the prescaled tick
// assumes cfg only changes while run is low; scl pin is asynchronous
`timescale 1ns/10ps

module i2coa_timing import i2coa_pkg::*; #(
    parameter int CNT_W = 9
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstSyncN,
    // control
    input wire logic run,
    input wire i2coa_timing_cfg_t cfg,
    // scl open-drain pin
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // strobe for the sda driver
    output logic sdaChange
);

    generate
        if (CNT_W < 9) begin : g_chk
            $error("i2coa_timing: CNT_W must hold 256");
        end
    endgenerate

    logic [3:0] pscCnt_q;
    logic [CNT_W-1:0] phaseCnt_q;
    logic [4:0] setupCnt_q;
    logic sdaDone_q, sclMeta_q, sclSync_q, sclOe_q, sdaChange_q;
    i2coa_tstate_t state_q;

    // ==========================================================
    // prescaled tick
    wire tick = run && (pscCnt_q == cfg.psc);
    wire [CNT_W-1:0] lowEnd = CNT_W'(cfg.low) + CNT_W'(1);
    wire [CNT_W-1:0] highEnd = CNT_W'(cfg.high) + CNT_W'(1);
    wire [4:0] setupEnd = {1'b0, cfg.setup} + 5'h1;
    wire holdHit = !sdaDone_q && (phaseCnt_q == CNT_W'(cfg.hold));
    wire lowDone = (phaseCnt_q >= lowEnd) && sdaDone_q && (setupCnt_q >= setupEnd);
    wire highDone = phaseCnt_q >= highEnd;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            pscCnt_q <= 4'h0;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            pscCnt_q <= (tick || !run) ? 4'h0 : pscCnt_q + 4'h1;
        end
    end

    // ==========================================================
    // phase sequencer
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_q <= TS_IDLE;
            phaseCnt_q <= '0;
            setupCnt_q <= 5'h0;
            sdaDone_q <= 1'b0;
            sclOe_q <= 1'b0;
            sdaChange_q <= 1'b0;
        end else if (!run && state_q != TS_IDLE) begin
            // a disable mid-phase lets scl go instead of holding the bus low forever
            state_q <= TS_IDLE;
            sclOe_q <= 1'b0;
            sdaChange_q <= 1'b0;
        end else begin
            sdaChange_q <= 1'b0;
            case (state_q)
                TS_IDLE: begin
                    if (run) begin
                        state_q <= TS_LOW;
                        sclOe_q <= 1'b1;
                        phaseCnt_q <= '0;
                        setupCnt_q <= 5'h0;
                        sdaDone_q <= 1'b0;
                    end
                end
                TS_LOW: begin
                    if (holdHit) begin
                        sdaDone_q <= 1'b1;
                        sdaChange_q <= 1'b1;
                    end
                    if (lowDone) begin
                        state_q <= TS_HIGH;
                        sclOe_q <= 1'b0;
                        phaseCnt_q <= '0;
                    end else if (tick) begin
                        phaseCnt_q <= phaseCnt_q + CNT_W'(1);
                        if (sdaDone_q && setupCnt_q < setupEnd) begin
                            setupCnt_q <= setupCnt_q + 5'h1;
                        end
                    end
                end
                TS_HIGH: begin
                    // a stretching slave holds the high count until scl is seen high
                    if (highDone) begin
                        state_q <= run ? TS_LOW : TS_IDLE;
                        sclOe_q <= run;
                        phaseCnt_q <= '0;
                        setupCnt_q <= 5'h0;
                        sdaDone_q <= 1'b0;
                    end else if (tick && sclSync_q) begin
                        phaseCnt_q <= phaseCnt_q + CNT_W'(1);
                    end
                end
                default: state_q <= TS_IDLE;
            endcase
        end
    end

    assign sclOe = sclOe_q;
    assign sclOut = 1'b0;
    assign sdaChange = sdaChange_q;

    // ==========================================================
    // checks
    property p_psc_tick;
        @(posedge clk) disable iff (!rstSyncN)
        tick && run && cfg.psc == 4'h1 |=> !tick ##1 (tick || !run);
    endproperty
    a_psc_tick: assert property (p_psc_tick) else $error("prescaler period wrong");

    property p_rise_after_setup;
        @(posedge clk) disable iff (!rstSyncN)
        $fell(sclOe_q) && $past(run) |->
            $past(state_q == TS_LOW) && $past(setupCnt_q) >= $past(setupEnd) &&
            $past(phaseCnt_q) >= $past(lowEnd);
    endproperty
    a_rise_after_setup: assert property (p_rise_after_setup) else $error("scl rose early");

    property p_hold_point;
        @(posedge clk) disable iff (!rstSyncN)
        sdaChange_q |-> $past(phaseCnt_q) == CNT_W'(cfg.hold);
    endproperty
    a_hold_point: assert property (p_hold_point) else $error("sda moved off hold point");

    c_sda_change: cover property (@(posedge clk) disable iff (!rstSyncN) sdaChange_q);
    c_full_bit: cover property (@(posedge clk) disable iff (!rstSyncN)
        $fell(sclOe_q) ##[1:1000] $rose(sclOe_q));

endmodule

// ==== i2coa_bus_model.sv ====
// far side of the scl line: pull-up resistor plus a slave that may stretch the clock
// assumes sclOut/sclOe come from the design; the bench sets the stretch length
`timescale 1ns/10ps

module i2coa_bus_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // design pin
    input wire logic sclOut,
    input wire logic sclOe,
    // bench command, 0 answers promptly
    input wire logic [7:0] stretch,
    // resolved wire
    output logic sclWire
);
    // ==========================================
    // stretch after each release of scl
    logic oeLast_q;
    logic [7:0] holdCnt_q;
    logic released;
    logic pullLow;

    assign released = oeLast_q && !sclOe && (stretch != 8'h00);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oeLast_q <= 1'b0;
            holdCnt_q <= 8'h00;
        end else begin
            oeLast_q <= sclOe;
            if (released) begin
                holdCnt_q <= stretch - 8'h01;
            end else if (holdCnt_q != 8'h00) begin
                holdCnt_q <= holdCnt_q - 8'h01;
            end
        end
    end

    // open drain: the pull-up wins only while nobody pulls
    assign pullLow = (sclOe && !sclOut) || (holdCnt_q != 8'h00) || released;
    assign sclWire = pullLow ? 1'b0 : 1'b1;
endmodule

// ==== i2coa_top_tb.sv ====
// self-checking bench for own-address matching, status/irq and scl timing
// assumes one ref_clk domain; the bus model resolves the scl wire
`timescale 1ns/10ps
`include "i2coa_map.svh"

module i2coa_top_tb import i2coa_pkg::*; ;
    typedef struct packed {
        logic [31:0] a1;
        logic [31:0] a2;
        logic ten;
        logic [9:0] rx;
        logic ack;
    } i2coa_row_t;

    // ==========================================
    // signals, tables and instances
    logic ref_clk, rstn, regWr, regRd, addrDone, addrAck, addressMatchFlag;
    logic peripheralEnable, irq, sclWire, sclOut, sclOe, sdaChange;
    logic [7:0] regAddr, stretch;
    logic [9:0] rx10;
    logic [31:0] regWdata, regRdata, rd, prevA2, a2v;
    i2coa_rxaddr_t rxAddr;
    i2coa_timing_cfg_t t;
    int errors = 0;
    int n_tests = 0;
    int sdaAt, lowC, highC, n, p, lowExp;
    localparam logic [7:0] OFS [6] = '{8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28};
    localparam logic [7:0] WOFS [5] = '{8'h08, 8'h0c, 8'h10, 8'h3c, 8'h28};
    localparam logic [31:0] WEXP [5] = '{32'h87ff, 32'h87fe, 32'hf0ff_ffff, 32'h0, 32'h3};
    // second entry: low phase stretched by hold plus setup
    localparam logic [31:0] CFG [2] = '{32'h1012_0409, 32'h0065_0200};
    localparam i2coa_row_t ROWS [18] = '{
        '{32'h8355, 32'h0, 1'b0, 10'h02a, 1'b1}, '{32'h8355, 32'h0, 1'b0, 10'h02b, 1'b0},
        '{32'h86b5, 32'h0, 1'b1, 10'h2b5, 1'b1}, '{32'h86b5, 32'h0, 1'b1, 10'h2b4, 1'b0},
        '{32'h86b5, 32'h0, 1'b0, 10'h05a, 1'b0}, '{32'h8355, 32'h0, 1'b1, 10'h02a, 1'b0},
        '{32'h0054, 32'h0, 1'b0, 10'h02a, 1'b0}, '{32'h0, 32'h8062, 1'b0, 10'h031, 1'b1},
        '{32'h0, 32'h0062, 1'b0, 10'h031, 1'b0}, '{32'h0, 32'h87aa, 1'b0, 10'h013, 1'b1},
        '{32'h0, 32'h87aa, 1'b0, 10'h005, 1'b0}, '{32'h0, 32'h87aa, 1'b0, 10'h07c, 1'b0},
        '{32'h0, 32'h87aa, 1'b1, 10'h013, 1'b0}, '{32'h0, 32'h8008, 1'b0, 10'h004, 1'b1},
        '{32'h0, 32'h8108, 1'b0, 10'h005, 1'b0}, '{32'h8022, 32'h8044, 1'b0, 10'h011, 1'b1},
        '{32'h8022, 32'h8044, 1'b0, 10'h022, 1'b1}, '{32'h8022, 32'h8044, 1'b1, 10'h022, 1'b0}
    };

    i2coa_top uut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxAddr(rxAddr), .addrDone(addrDone),
        .addrAck(addrAck), .addressMatchFlag(addressMatchFlag),
        .peripheralEnable(peripheralEnable), .irq(irq), .sclIn(sclWire), .sclOut(sclOut),
        .sclOe(sclOe), .sdaChange(sdaChange));
    i2coa_bus_model farSide (.ref_clk(ref_clk), .rstn(rstn), .sclOut(sclOut), .sclOe(sclOe),
        .stretch(stretch), .sclWire(sclWire));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ==========================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic sendAddr(input logic ten, input logic [9:0] a, input logic expDone);
        @(posedge ref_clk);
        rxAddr <= '{valid: 1'b1, is10: ten, addr: a};
        @(posedge ref_clk);
        rxAddr <= '0;
        #1;
        check("addrDone", 32'(addrDone), 32'(expDone));
    endtask

    task automatic runRow(input i2coa_row_t r);
        regWrite(`I2COA_OFS_PRIMARY_OWN_ADDR, r.a1);
        // the mask only moves while the second address is disabled
        regWrite(`I2COA_OFS_SECONDARY_OWN_ADDR, prevA2 & 32'h7fff);
        regWrite(`I2COA_OFS_SECONDARY_OWN_ADDR, r.a2 & 32'h7fff);
        regWrite(`I2COA_OFS_SECONDARY_OWN_ADDR, r.a2);
        prevA2 = r.a2;
        regWrite(`I2COA_OFS_STATUS, 32'h3);
        sendAddr(r.ten, r.rx, 1'b1);
        check("addrAck", 32'(addrAck), 32'(r.ack));
        check("matchFlag", 32'(addressMatchFlag), 32'(r.ack));
        @(posedge ref_clk);
        #1;
        check("irq", 32'(irq), 32'(r.ack));
    endtask

    task automatic waitOe(input logic v, output int cnt);
        cnt = 0;
        while (sclOe !== v) begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (sdaChange === 1'b1) sdaAt = cnt;
            if (cnt > 800) begin
                errors++;
                $display("ERROR sclOe expected %b seen no change", v);
                conclude();
            end
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        rxAddr = '0;
        stretch = 8'h00;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("sclOe", 32'(sclOe), 32'h0);
        foreach (OFS[i]) begin
            regRead(OFS[i], rd);
            check("resetValue", rd, 32'h0);
        end
        foreach (WOFS[i]) begin
            regWrite(WOFS[i], 32'hffff_ffff);
            regRead(WOFS[i], rd);
            check("writeMask", rd, WEXP[i]);
        end
        @(posedge ref_clk);
        #1;
        check("rdataIdle", regRdata, 32'h0);
        prevA2 = 32'h87fe;
        regWrite(`I2COA_OFS_MASK, 32'h1);
        regWrite(`I2COA_OFS_CTRL, 32'h1);
        foreach (ROWS[i]) runRow(ROWS[i]);
        check("enableOn", 32'({peripheralEnable, sclOut}), 32'h2);
        // low bits flipped inside the mask match, the next bit up does not
        for (int m = 0; m < 7; m++) begin
            rx10 = 10'h02a ^ ((10'h001 << m) - 10'h001);
            a2v = 32'h8054 | (32'(m) << 8);
            runRow('{32'h0, a2v, 1'b0, rx10, 1'b1});
            runRow('{32'h0, a2v, 1'b0, rx10 ^ (10'h001 << m), 1'b0});
        end
        regWrite(`I2COA_OFS_MASK, 32'h0);
        sendAddr(1'b0, 10'h015, 1'b1);
        @(posedge ref_clk);
        #1;
        check("irqMasked", 32'({addressMatchFlag, irq}), 32'h2);
        regWrite(`I2COA_OFS_MASK, 32'h1);
        @(posedge ref_clk);
        #1;
        check("irqUnmasked", 32'(irq), 32'h1);
        regWrite(`I2COA_OFS_STATUS, 32'h1);
        @(posedge ref_clk);
        #1;
        check("flagClear", 32'({addressMatchFlag, irq}), 32'h0);
        regWrite(`I2COA_OFS_STATUS, 32'h3);
        regWrite(`I2COA_OFS_MASK, 32'h2);
        sendAddr(1'b0, 10'h055, 1'b1);
        @(posedge ref_clk);
        #1;
        check("irqNomatch", 32'(irq), 32'h1);
        regRead(`I2COA_OFS_STATUS, rd);
        check("status", rd, 32'h2);
        regWrite(`I2COA_OFS_STATUS, 32'h2);
        regWrite(`I2COA_OFS_PRIMARY_OWN_ADDR, 32'h802a);
        sendAddr(1'b0, 10'h015, 1'b1);
        regWrite(`I2COA_OFS_CTRL, 32'h0);
        regRead(`I2COA_OFS_STATUS, rd);
        check("statusOff", rd, 32'h0);
        check("enableOff", 32'({peripheralEnable, addressMatchFlag}), 32'h0);
        sendAddr(1'b0, 10'h015, 1'b0);
        regWrite(`I2COA_OFS_TIMING, CFG[0]);
        regWrite(`I2COA_OFS_CTRL, 32'h3);
        regWrite(`I2COA_OFS_TIMING, CFG[1]);
        regRead(`I2COA_OFS_TIMING, rd);
        check("timingLocked", rd, CFG[0]);
        for (int c = 0; c < 3; c++) begin
            t = CFG[(c == 0) ? 0 : 1];
            // third pass repeats the second with the far side stretching scl
            stretch <= (c == 2) ? 8'd20 : 8'd0;
            if (c < 2) begin
                regWrite(`I2COA_OFS_CTRL, 32'h0);
                regWrite(`I2COA_OFS_TIMING, t);
                regWrite(`I2COA_OFS_CTRL, 32'h3);
            end
            p = int'(t.psc) + 1;
            lowExp = p * ((int'(t.low) > int'(t.hold) + int'(t.setup)) ?
                int'(t.low) + 1 : int'(t.hold) + int'(t.setup) + 1);
            waitOe(1'b0, n);
            waitOe(1'b1, n);
            sdaAt = -1;
            waitOe(1'b0, lowC);
            waitOe(1'b1, highC);
            n = (c == 2) ? 20 : 0;
            check("sclLow", 32'(lowC >= lowExp && lowC <= lowExp + 3), 32'h1);
            n_tests++;
            check("sdaHold", 32'(sdaAt >= int'(t.hold) * p && sdaAt <= int'(t.hold) * p + 2),
                32'h1);
            check("sdaSetup", 32'(lowC - sdaAt >= (int'(t.setup) + 1) * p), 32'h1);
            check("sclHigh", 32'(highC >= (int'(t.high) + 1) * p + n &&
                highC <= (int'(t.high) + 1) * p + n + 5), 32'h1);
        end
        conclude();
    end
endmodule
